// ---- common/rsiu_pkg.sv ----
package rsiu_pkg;
	//------------------------------------------------------------
	// instruction encodings
	//------------------------------------------------------------
	localparam logic [7:0] OP_Q_TX_CAL    = 8'hC1; // queued tx calibrate
	localparam logic [7:0] OP_Q_RX_EN     = 8'hC2; // queued rx enable
	localparam logic [7:0] OP_Q_TX_EN     = 8'hC3; // queued tx enable
	localparam logic [7:0] OP_Q_TX_CLR    = 8'hC4; // queued tx if clear
	localparam logic [7:0] OP_Q_RF_OFF    = 8'hC5; // queued radio off
	localparam logic [7:0] OP_Q_RX_FLUSH  = 8'hC6; // queued rx flush
	localparam logic [7:0] OP_Q_TX_FLUSH  = 8'hC7; // queued tx flush
	localparam logic [7:0] OP_Q_ACK       = 8'hC8; // queued ack
	localparam logic [7:0] OP_Q_ACK_PEND  = 8'hC9; // queued ack pending
	localparam logic [7:0] OP_Q_HALT      = 8'hDF; // queued stop
	localparam logic [7:0] OP_I_HALT      = 8'hFF; // immediate halt
	localparam logic [7:0] OP_I_RUN       = 8'hFE; // immediate run
	localparam logic [7:0] OP_I_TX_CAL    = 8'hE1; // immediate tx calibrate
	localparam logic [7:0] OP_I_RX_EN     = 8'hE2; // immediate rx enable
	localparam logic [7:0] OP_I_TX_EN     = 8'hE3; // immediate tx enable
	localparam logic [7:0] OP_I_TX_CLR    = 8'hE4; // immediate tx if clear
	localparam logic [7:0] OP_I_RF_OFF    = 8'hE5; // immediate radio off
	localparam logic [7:0] OP_I_RX_FLUSH  = 8'hE6; // immediate rx flush
	localparam logic [7:0] OP_I_TX_FLUSH  = 8'hE7; // immediate tx flush
	localparam logic [7:0] OP_I_ACK       = 8'hE8; // immediate ack
	localparam logic [7:0] OP_I_ACK_PEND  = 8'hE9; // immediate ack pending
	//------------------------------------------------------------
	// strobe field: low nibble of a strobe opcode
	//------------------------------------------------------------
	localparam int           STB_LSB      = 0;      // strobe index lsb
	localparam int           STB_W        = 4;      // strobe index width
	localparam int           NUM_STB      = 9;      // strobe outputs
	localparam logic [3:0]   GRP_QUEUED   = 4'hC;   // high nibble, queued
	localparam logic [3:0]   GRP_IMMED    = 4'hE;   // high nibble, immediate
	localparam logic [3:0]   STB_FIRST    = 4'h1;   // lowest strobe code
	localparam logic [3:0]   STB_LAST     = 4'h9;   // highest strobe code
	//------------------------------------------------------------
	// memory and reset values
	//------------------------------------------------------------
	localparam int           IMEM_DEPTH   = 24;     // instruction words
	localparam logic [4:0]   PC_RESET     = 5'h00;  // pc after reset/halt
	localparam logic [7:0]   INSTR_RESET  = 8'h00;  // cleared word
	//------------------------------------------------------------
	// controller states
	//------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FETCH,
		ST_WAIT
	} rsiu_state_t;
endpackage : rsiu_pkg

// ---- rtl/rsiu_imem.sv ----
`timescale 1ns/1ps
`default_nettype none
// instruction store; halt clears every word
module rsiu_imem #(
	parameter int DEPTH = rsiu_pkg::IMEM_DEPTH,
	parameter int AW    = 5
) (
	// clock and reset
	input  wire logic          clk_sys,
	input  wire logic          resetn,
	input  wire logic          ce,
	// write side
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [7:0]    wr_data,
	input  wire logic          clear,
	// read side
	input  wire logic [AW-1:0] rd_addr,
	output logic      [7:0]    rd_data
);
	logic [7:0] mem_reg [DEPTH];     // program words

	//------------------------------------------------------------
	// storage
	//------------------------------------------------------------
	// clear wins over write: a halt discards the whole program
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < DEPTH; i++) mem_reg[i] <= rsiu_pkg::INSTR_RESET;
		end else if (ce) begin
			if (clear) begin
				for (int i = 0; i < DEPTH; i++) mem_reg[i] <= rsiu_pkg::INSTR_RESET;
			end else if (wr_en && (int'(wr_addr) < DEPTH)) begin
				mem_reg[wr_addr] <= wr_data;
			end
		end
	end

	// out-of-range reads give a cleared word
	assign rd_data = (int'(rd_addr) < DEPTH) ? mem_reg[rd_addr] : rsiu_pkg::INSTR_RESET;
endmodule : rsiu_imem
`default_nettype wire

// ---- rtl/rsiu_strobe_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
// maps an opcode to a one-hot strobe vector
module rsiu_strobe_decode (
	// opcode in
	input  wire logic [7:0] opcode,
	input  wire logic       immed,
	// decoded
	output logic            is_strobe,
	output logic [8:0]      onehot
);
	wire [3:0] grp = opcode[7:4];               // group nibble
	wire [3:0] idx = opcode[3:0];               // strobe index
	wire       grp_ok = immed ? (grp == rsiu_pkg::GRP_IMMED)
	                          : (grp == rsiu_pkg::GRP_QUEUED);
	wire       idx_ok = (idx >= rsiu_pkg::STB_FIRST) && (idx <= rsiu_pkg::STB_LAST);
	wire [3:0] bitno  = idx - rsiu_pkg::STB_FIRST;

	assign is_strobe = grp_ok && idx_ok;
	assign onehot    = is_strobe ? (9'h001 << bitno) : 9'h000;
endmodule : rsiu_strobe_decode
`default_nettype wire

// ---- rtl/rsiu_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// radio command sequencer: issue and ack handshake
module rsiu_top #(
	parameter int DEPTH = rsiu_pkg::IMEM_DEPTH,
	parameter int AW    = 5
) (
	// clock, reset, enable
	input  wire logic clk_sys,
	input  wire logic resetn,
	input  wire logic ce,
	// cpu instruction write
	input  wire logic       instr_wr,
	input  wire logic [7:0] instr_data,
	// radio handshake
	input  wire logic       radio_ack,
	// strobes toward the radio
	output logic            tx_calibrate_pulse,
	output logic            rx_enable_pulse,
	output logic            tx_enable_pulse,
	output logic            tx_if_clear_pulse,
	output logic            radio_off_pulse,
	output logic            rx_flush_pulse,
	output logic            tx_flush_pulse,
	output logic            ack_send_pulse,
	output logic            ack_pending_send_pulse,
	// status
	output logic            running,
	output logic            busy,
	output logic            sequencer_halt_irq_flag,
	output logic            label_valid,
	output logic [AW-1:0]   pc_out,
	output logic [AW-1:0]   wr_ptr_out
);
	// every check below samples on the system clock, idle in reset
	default clocking cb_sys @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	//------------------------------------------------------------
	// state
	//------------------------------------------------------------
	rsiu_pkg::rsiu_state_t state_reg, state_next; // controller state
	logic [AW-1:0] pc_reg, pc_next;               // program counter
	logic [AW-1:0] wp_reg, wp_next;               // write pointer
	logic [8:0]    stb_reg, stb_next;             // strobe outputs
	logic          run_reg, run_next;             // program running
	logic          irq_reg, irq_next;             // halt flag, sticky
	logic          lbl_reg, lbl_next;             // loop label valid
	logic          imm_wait_reg, imm_wait_next;   // immediate in flight
	logic          busy_reg, busy_next;           // registered stall flag

	//------------------------------------------------------------
	// decode of cpu word and fetched word
	//------------------------------------------------------------
	wire [7:0] fetch_word;                        // word at pc
	wire       cpu_stb;                           // cpu word is strobe
	wire [8:0] cpu_onehot;                        // its strobe vector
	wire       mem_stb;                           // fetched is strobe
	wire [8:0] mem_onehot;                        // its strobe vector

	rsiu_strobe_decode u_dec_cpu (
		.opcode    (instr_data),
		.immed     (1'b1),
		.is_strobe (cpu_stb),
		.onehot    (cpu_onehot)
	);
	rsiu_strobe_decode u_dec_mem (
		.opcode    (fetch_word),
		.immed     (1'b0),
		.is_strobe (mem_stb),
		.onehot    (mem_onehot)
	);

	// immediate words never reach memory
	wire cpu_halt  = instr_wr && (instr_data == rsiu_pkg::OP_I_HALT);
	wire cpu_run   = instr_wr && (instr_data == rsiu_pkg::OP_I_RUN);
	wire cpu_imm   = instr_wr && cpu_stb;
	wire cpu_store = instr_wr && !cpu_halt && !cpu_run && !cpu_stb;
	wire waiting   = (state_reg == rsiu_pkg::ST_WAIT);
	wire mem_halt  = (fetch_word == rsiu_pkg::OP_Q_HALT);
	wire pc_end    = (int'(pc_reg) >= DEPTH - 1);
	wire do_halt   = cpu_halt || ((state_reg == rsiu_pkg::ST_FETCH) && mem_halt);
	wire mem_clear = ce && do_halt;

	rsiu_imem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.ce      (ce),
		.wr_en   (cpu_store && !do_halt),
		.wr_addr (wp_reg),
		.wr_data (instr_data),
		.clear   (mem_clear),
		.rd_addr (pc_reg),
		.rd_data (fetch_word)
	);

	//------------------------------------------------------------
	// next-state logic
	//------------------------------------------------------------
	// an immediate strobe may not collide with a wait in progress;
	// a cpu strobe issued mid-wait is dropped, software must poll busy
	always_comb begin
		state_next    = state_reg;
		pc_next       = pc_reg;
		wp_next       = wp_reg;
		stb_next      = 9'h000;
		run_next      = run_reg;
		irq_next      = irq_reg;
		lbl_next      = lbl_reg;
		imm_wait_next = imm_wait_reg;
		if (cpu_store && int'(wp_reg) < DEPTH) begin
			wp_next = wp_reg + AW'(1);
		end
		case (state_reg)
			// idle: only run or an immediate does anything
			rsiu_pkg::ST_IDLE: begin
				if (cpu_run) begin
					pc_next    = rsiu_pkg::PC_RESET[AW-1:0];
					run_next   = 1'b1;
					state_next = rsiu_pkg::ST_FETCH;
				end else if (cpu_imm) begin
					stb_next      = cpu_onehot;
					imm_wait_next = 1'b1;
					state_next    = rsiu_pkg::ST_WAIT;
				end
			end
			// an immediate pre-empts the fetched word
			rsiu_pkg::ST_FETCH: begin
				if (cpu_imm) begin
					stb_next      = cpu_onehot;
					imm_wait_next = 1'b1;
					state_next    = rsiu_pkg::ST_WAIT;
				end else if (mem_stb) begin
					stb_next   = mem_onehot;
					state_next = rsiu_pkg::ST_WAIT;
				end else if (pc_end) begin
					run_next   = 1'b0;
					state_next = rsiu_pkg::ST_IDLE;
				end else begin
					pc_next = pc_reg + AW'(1);
				end
			end
			// queued words advance, immediates leave pc alone
			rsiu_pkg::ST_WAIT: begin
				if (radio_ack) begin
					imm_wait_next = 1'b0;
					if (!imm_wait_reg && pc_end) begin
						run_next   = 1'b0;
						state_next = rsiu_pkg::ST_IDLE;
					end else begin
						if (!imm_wait_reg) pc_next = pc_reg + AW'(1);
						state_next = run_reg ? rsiu_pkg::ST_FETCH : rsiu_pkg::ST_IDLE;
					end
				end
			end
			default: state_next = rsiu_pkg::ST_IDLE;
		endcase
		// halt overrides whatever the case chose
		if (do_halt) begin
			pc_next       = rsiu_pkg::PC_RESET[AW-1:0];
			wp_next       = rsiu_pkg::PC_RESET[AW-1:0];
			run_next      = 1'b0;
			lbl_next      = 1'b0;
			irq_next      = 1'b1;
			stb_next      = 9'h000;
			imm_wait_next = 1'b0;
			state_next    = rsiu_pkg::ST_IDLE;
		end
	end

	// busy is registered so the port comes straight from a flop
	assign busy_next = (state_next == rsiu_pkg::ST_WAIT);

	//------------------------------------------------------------
	// registers
	//------------------------------------------------------------
	// ce low freezes every flop, strobes included
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_reg    <= rsiu_pkg::ST_IDLE;
			pc_reg       <= '0;
			wp_reg       <= '0;
			stb_reg      <= 9'h000;
			run_reg      <= 1'b0;
			irq_reg      <= 1'b0;
			lbl_reg      <= 1'b0;
			imm_wait_reg <= 1'b0;
			busy_reg     <= 1'b0;
		end else if (ce) begin
			state_reg    <= state_next;
			pc_reg       <= pc_next;
			wp_reg       <= wp_next;
			stb_reg      <= stb_next;
			run_reg      <= run_next;
			irq_reg      <= irq_next;
			lbl_reg      <= lbl_next;
			imm_wait_reg <= imm_wait_next;
			busy_reg     <= busy_next;
		end
	end

	//------------------------------------------------------------
	// outputs, all straight from flip-flops
	//------------------------------------------------------------
	assign tx_calibrate_pulse      = stb_reg[0];
	assign rx_enable_pulse         = stb_reg[1];
	assign tx_enable_pulse         = stb_reg[2];
	assign tx_if_clear_pulse       = stb_reg[3];
	assign radio_off_pulse         = stb_reg[4];
	assign rx_flush_pulse          = stb_reg[5];
	assign tx_flush_pulse          = stb_reg[6];
	assign ack_send_pulse          = stb_reg[7];
	assign ack_pending_send_pulse  = stb_reg[8];
	assign running                 = run_reg;
	assign busy                    = busy_reg;
	assign sequencer_halt_irq_flag = irq_reg;
	assign label_valid             = lbl_reg;
	assign pc_out                  = pc_reg;
	assign wr_ptr_out              = wp_reg;

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	sequence s_strobe;
		|stb_reg;
	endsequence
	sequence s_wait_hold;
		waiting && !radio_ack && ce && !do_halt;
	endsequence
	// a cpu strobe word taken while not stalled
	sequence s_imm_take;
		ce && cpu_imm && !do_halt && !waiting;
	endsequence
	// a stored word fetched with no cpu strobe competing
	sequence s_fetch_take;
		ce && (state_reg == rsiu_pkg::ST_FETCH) && !cpu_imm && !do_halt;
	endsequence
	// the radio answers a stall and no halt overrides it
	sequence s_wait_ack;
		waiting && radio_ack && ce && !do_halt;
	endsequence

	a_strobe_one_cycle: assert property (@(posedge clk_sys) disable iff (!resetn)
		(s_strobe and ce) |=> !(|stb_reg) || !ce)
		else $error("strobe longer than one cycle");
	a_strobe_onehot: assert property (@(posedge clk_sys) disable iff (!resetn)
		$onehot0(stb_reg))
		else $error("more than one strobe at once");
	a_wait_holds_pc: assert property (@(posedge clk_sys) disable iff (!resetn)
		s_wait_hold |=> $stable(pc_reg) && waiting)
		else $error("advanced without radio ack");
	a_halt_clears: assert property (@(posedge clk_sys) disable iff (!resetn)
		(ce && do_halt) |=> pc_reg == '0 && wp_reg == '0 && !run_reg)
		else $error("halt left pc or pointer set");
	a_halt_flag: assert property (@(posedge clk_sys) disable iff (!resetn)
		(ce && do_halt) |=> irq_reg && !lbl_reg)
		else $error("halt flag not raised");
	a_run_start: assert property (@(posedge clk_sys) disable iff (!resetn)
		(ce && cpu_run && !do_halt && state_reg == rsiu_pkg::ST_IDLE)
		|=> run_reg && pc_reg == '0 && state_reg == rsiu_pkg::ST_FETCH)
		else $error("run did not start at zero");
	a_imm_strobe: assert property (@(posedge clk_sys) disable iff (!resetn)
		(ce && cpu_imm && !do_halt && state_reg == rsiu_pkg::ST_IDLE)
		|=> stb_reg == $past(cpu_onehot) && waiting)
		else $error("immediate strobe not issued");
	a_imm_no_store: assert property (@(posedge clk_sys) disable iff (!resetn)
		(ce && (cpu_imm || cpu_run)) |=> $stable(wp_reg) || wp_reg == '0)
		else $error("immediate word stored");
	a_queued_strobe: assert property (@(posedge clk_sys) disable iff (!resetn)
		(ce && state_reg == rsiu_pkg::ST_FETCH && mem_stb && !cpu_imm && !do_halt)
		|=> stb_reg == $past(mem_onehot) ##1 (!(|stb_reg) || !$past(ce)))
		else $error("queued strobe not issued");

	// each immediate code lands on its own strobe pin
	a_imm_tx_cal: assert property (
		(s_imm_take and instr_data == rsiu_pkg::OP_I_TX_CAL) |=> tx_calibrate_pulse)
		else $error("tx calibrate strobe missing");
	a_imm_rx_en: assert property (
		(s_imm_take and instr_data == rsiu_pkg::OP_I_RX_EN) |=> rx_enable_pulse)
		else $error("rx enable strobe missing");
	a_imm_tx_en: assert property (
		(s_imm_take and instr_data == rsiu_pkg::OP_I_TX_EN) |=> tx_enable_pulse)
		else $error("tx enable strobe missing");
	a_imm_tx_clr: assert property (
		(s_imm_take and instr_data == rsiu_pkg::OP_I_TX_CLR) |=> tx_if_clear_pulse)
		else $error("tx if clear strobe missing");
	a_imm_rf_off: assert property (
		(s_imm_take and instr_data == rsiu_pkg::OP_I_RF_OFF) |=> radio_off_pulse)
		else $error("radio off strobe missing");
	a_imm_rx_flush: assert property (
		(s_imm_take and instr_data == rsiu_pkg::OP_I_RX_FLUSH) |=> rx_flush_pulse)
		else $error("rx flush strobe missing");
	a_imm_tx_flush: assert property (
		(s_imm_take and instr_data == rsiu_pkg::OP_I_TX_FLUSH) |=> tx_flush_pulse)
		else $error("tx flush strobe missing");
	a_imm_ack: assert property (
		(s_imm_take and instr_data == rsiu_pkg::OP_I_ACK) |=> ack_send_pulse)
		else $error("ack strobe missing");
	a_imm_ack_pend: assert property (
		(s_imm_take and instr_data == rsiu_pkg::OP_I_ACK_PEND) |=> ack_pending_send_pulse)
		else $error("ack pending strobe missing");

	// queued codes C6 to C9 each land on their own strobe pin
	a_q_rx_flush: assert property (
		(s_fetch_take and fetch_word == rsiu_pkg::OP_Q_RX_FLUSH) |=> rx_flush_pulse)
		else $error("queued rx flush missing");
	a_q_tx_flush: assert property (
		(s_fetch_take and fetch_word == rsiu_pkg::OP_Q_TX_FLUSH) |=> tx_flush_pulse)
		else $error("queued tx flush missing");
	a_q_ack: assert property (
		(s_fetch_take and fetch_word == rsiu_pkg::OP_Q_ACK) |=> ack_send_pulse)
		else $error("queued ack missing");
	a_q_ack_pend: assert property (
		(s_fetch_take and fetch_word == rsiu_pkg::OP_Q_ACK_PEND) |=> ack_pending_send_pulse)
		else $error("queued ack pending missing");

	// the answer ends the stall on the next edge
	a_ack_releases: assert property (
		s_wait_ack |=> !waiting)
		else $error("stall outlived radio ack");
	// a queued word answered mid-program moves on by one word
	a_queued_advance: assert property (
		(s_wait_ack and !imm_wait_reg && !pc_end) |=> pc_reg == $past(pc_reg) + AW'(1))
		else $error("program order broken");
	// an answered immediate leaves the program where it was
	a_imm_keeps_pc: assert property (
		(s_wait_ack and imm_wait_reg) |=> $stable(pc_reg))
		else $error("immediate moved the pc");
	// after a halt the word at pc reads as cleared
	a_halt_wipes_mem: assert property (
		(ce && do_halt) |=> fetch_word == rsiu_pkg::INSTR_RESET)
		else $error("memory not cleared by halt");
	// a strobe is only shown while its answer is awaited
	a_strobe_in_wait: assert property (
		(|stb_reg) |-> waiting)
		else $error("strobe outside a stall");
	// a strobe word offered while stalled issues nothing
	a_busy_drops: assert property (
		(ce && waiting && cpu_imm && !do_halt) |=> !(|stb_reg))
		else $error("strobe issued while stalled");
endmodule : rsiu_top
`default_nettype wire

// ---- verification/rsiu_radio_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// radio control side: answers each strobe with a one-cycle acknowledge
module rsiu_radio_model (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	// strobes from the sequencer, bit n = strobe code n+1
	input  wire logic [8:0] pulses,
	// cycles to wait before acknowledging, set by the bench
	input  wire logic [3:0] ack_delay,
	// acknowledge back to the sequencer
	output logic            radio_ack
);
	//------------------------------------------------------------
	// acknowledge timing
	//------------------------------------------------------------
	logic [3:0] cnt_reg;  // cycles left before acknowledge
	logic       pend_reg; // a strobe awaits its acknowledge

	// one acknowledge per strobe; slow delays hold the sequencer stalled
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cnt_reg   <= 4'h0;
			pend_reg  <= 1'b0;
			radio_ack <= 1'b0;
		end else begin
			radio_ack <= 1'b0;
			if (pulses != 9'h000) begin
				// new command latched, delay chosen now
				pend_reg <= 1'b1;
				cnt_reg  <= ack_delay;
			end else if (pend_reg && cnt_reg == 4'h0) begin
				// every strobe gets exactly one acknowledge
				radio_ack <= 1'b1;
				pend_reg  <= 1'b0;
			end else if (pend_reg) begin
				cnt_reg <= cnt_reg - 4'h1;
			end
		end
	end
endmodule : rsiu_radio_model
`default_nettype wire

// ---- verification/radio_strobe_instruction_unit_test.sv ----
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the strobe sequencer
module radio_strobe_instruction_unit_test;
	//------------------------------------------------------------
	// signals
	//------------------------------------------------------------
	logic       clk_sys;     // 50 MHz system clock
	logic       resetn;      // async reset, active low
	logic       ce;          // advance enable
	logic       instr_wr;    // cpu write strobe
	logic [7:0] instr_data;  // cpu opcode
	logic       radio_ack;   // from radio model
	logic [8:0] pulses;      // all nine strobes
	logic       running;     // program executing
	logic       busy;        // awaiting acknowledge
	logic       halt_flag;   // sticky halt flag
	logic       label_valid; // loop start valid
	logic [4:0] pc_out;      // program counter
	logic [4:0] wr_ptr_out;  // memory write pointer
	logic [3:0] ack_delay;   // radio answer delay
	logic       outstanding; // strobe not yet acknowledged
	logic [8:0] seen_q[$];   // strobes observed, in order
	logic [7:0] prog[10];    // queued program
	int         err_count;
	int         checked;
	int         seed;
	int         n;

	//------------------------------------------------------------
	// design and radio model
	//------------------------------------------------------------
	rsiu_top rsiu_top_i (
		.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
		.instr_wr(instr_wr), .instr_data(instr_data), .radio_ack(radio_ack),
		.tx_calibrate_pulse(pulses[0]), .rx_enable_pulse(pulses[1]),
		.tx_enable_pulse(pulses[2]), .tx_if_clear_pulse(pulses[3]),
		.radio_off_pulse(pulses[4]), .rx_flush_pulse(pulses[5]),
		.tx_flush_pulse(pulses[6]), .ack_send_pulse(pulses[7]),
		.ack_pending_send_pulse(pulses[8]), .running(running), .busy(busy),
		.sequencer_halt_irq_flag(halt_flag), .label_valid(label_valid),
		.pc_out(pc_out), .wr_ptr_out(wr_ptr_out)
	);
	rsiu_radio_model rsiu_radio_model_i (
		.clk_sys(clk_sys), .resetn(resetn), .pulses(pulses),
		.ack_delay(ack_delay), .radio_ack(radio_ack)
	);

	//------------------------------------------------------------
	// clock, monitor, watchdog
	//------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// a strobe lasting two cycles is logged twice and shows up as a count error
	always @(posedge clk_sys) begin
		if (resetn !== 1'b1) begin
			// nothing is owed to the radio while reset holds
			outstanding = 1'b0;
		end else begin
			if (radio_ack === 1'b1) outstanding = 1'b0;
			if (pulses !== 9'h000) begin
				seen_q.push_back(pulses);
				chk("no_advance_before_ack", 16'h0, {15'h0, outstanding});
				outstanding = 1'b1;
			end
		end
	end

	// whole run needs a few hundred cycles; this is ample margin
	initial begin
		#400000;
		err_count++;
		stop_test();
	end

	//------------------------------------------------------------
	// helpers
	//------------------------------------------------------------
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// strobe code n drives output bit n-1
	function automatic logic [8:0] stb_vec(input logic [7:0] op);
		return 9'h001 << (op[3:0] - 4'h1);
	endfunction : stb_vec

	task automatic do_reset();
		resetn = 1'b0;
		outstanding = 1'b0;
		repeat (2) @(posedge clk_sys);
		#2;
		resetn = 1'b1;
	endtask : do_reset

	// one cpu write, taken at the next edge
	task automatic wr(input logic [7:0] op);
		@(posedge clk_sys);
		#2;
		instr_wr   = 1'b1;
		instr_data = op;
		@(posedge clk_sys);
		#2;
		instr_wr = 1'b0;
	endtask : wr

	// bounded wait: busy must rise, then fall after the acknowledge
	task automatic wait_idle();
		n = 0;
		while (busy !== 1'b1 && n < 4) begin
			@(posedge clk_sys);
			#2;
			n++;
		end
		chk("busy_raised", 16'h1, {15'h0, busy});
		n = 0;
		while (busy !== 1'b0 && n < 40) begin
			@(posedge clk_sys);
			#2;
			n++;
		end
		chk("busy_dropped", 16'h0, {15'h0, busy});
		repeat (2) @(posedge clk_sys);
		#2;
	endtask : wait_idle

	// immediate strobe: exactly one pulse of the right output
	task automatic do_imm(input logic [7:0] op);
		seen_q.delete();
		ack_delay = 4'($unsigned($random(seed)) % 9);
		wr(op);
		wait_idle();
		chk("pulse_count", 16'h1, 16'(seen_q.size()));
		chk("pulse_code", {7'h0, stb_vec(op)}, {7'h0, seen_q[0]});
	endtask : do_imm

	// bounded wait for the program to stop
	task automatic wait_stop();
		repeat (2) @(posedge clk_sys);
		#2;
		n = 0;
		while (running !== 1'b0 && n < 400) begin
			@(posedge clk_sys);
			#2;
			n++;
		end
		chk("running_end", 16'h0, {15'h0, running});
	endtask : wait_stop

	task automatic stop_test();
		$display("errors %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	//------------------------------------------------------------
	// main sequence
	//------------------------------------------------------------
	initial begin
		seed = 19638;
		err_count = 0;
		checked = 0;
		ce = 1'b1;
		instr_wr = 1'b0;
		instr_data = 8'h00;
		ack_delay = 4'h0;
		prog = '{8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'hC8, 8'hC9, 8'hDF};
		do_reset();
		chk("flag_after_reset", 16'h0, {15'h0, halt_flag});
		// every immediate strobe code, then a random mix
		for (int i = 1; i <= 9; i++) begin
			do_imm({4'hE, 4'(i)});
		end
		repeat (12) begin
			do_imm({4'hE, 4'(1 + $unsigned($random(seed)) % 9)});
		end
		// clock enable low: writes are not taken and nothing moves
		seen_q.delete();
		ce = 1'b0;
		wr(8'hE2);
		wr(8'hC6);
		repeat (2) @(posedge clk_sys);
		#2;
		chk("frozen_pulses", 16'h0, 16'(seen_q.size()));
		chk("frozen_busy", 16'h0, {15'h0, busy});
		ce = 1'b1;
		chk("imm_not_stored", 16'h0, {11'h0, wr_ptr_out});
		// second immediate while stalled is dropped
		seen_q.delete();
		ack_delay = 4'hC;
		wr(8'hE3);
		wr(8'hE5);
		wait_idle();
		chk("refused_count", 16'h1, 16'(seen_q.size()));
		chk("refused_code", {7'h0, stb_vec(8'hE3)}, {7'h0, seen_q[0]});
		// queued program, held until run, then issued in order
		do_reset();
		seen_q.delete();
		foreach (prog[k]) wr(prog[k]);
		chk("queued_held", 16'h0, 16'(seen_q.size()));
		chk("queued_stored", 16'hA, {11'h0, wr_ptr_out});
		ack_delay = 4'($unsigned($random(seed)) % 9);
		wr(8'hFE);
		wait_stop();
		chk("queued_count", 16'h9, 16'(seen_q.size()));
		for (int k = 0; k < 9; k++) begin
			chk("queued_code", {7'h0, stb_vec(prog[k])}, {7'h0, seen_q[k]});
		end
		chk("stop_flag", 16'h1, {15'h0, halt_flag});
		chk("stop_pc", 16'h0, {11'h0, pc_out});
		chk("stop_wptr", 16'h0, {11'h0, wr_ptr_out});
		// immediate halt clears memory and pointers
		do_reset();
		wr(8'hC6);
		wr(8'hC7);
		wr(8'hFF);
		repeat (2) @(posedge clk_sys);
		#2;
		chk("halt_flag", 16'h1, {15'h0, halt_flag});
		chk("halt_label", 16'h0, {15'h0, label_valid});
		chk("halt_pc", 16'h0, {11'h0, pc_out});
		chk("halt_wptr", 16'h0, {11'h0, wr_ptr_out});
		seen_q.delete();
		wr(8'hFE);
		wait_stop();
		chk("cleared_memory", 16'h0, 16'(seen_q.size()));
		stop_test();
	end
endmodule : radio_strobe_instruction_unit_test
`default_nettype wire
